/* File: hdl/qps_cfg.svh */
// Constants of the quad pot serial link: opcodes, fields, timing.
// Assumes one 250 MHz system clock on both ends of the link.
`ifndef QPS_CFG_SVH
`define QPS_CFG_SVH
`define QPS_CLK_NS      4
`define QPS_NV_WRITE_NS 5000000
`define QPS_PWRUP_NS    1000000
`define QPS_SCK_MAX_KHZ 3000
`define QPS_NV_INIT     6'h00
`define QPS_DEV_TYPE    4'hA
`define QPS_OP_RD_WIPER 4'h9
`define QPS_OP_WR_WIPER 4'hA
`define QPS_OP_RD_SET   4'hB
`define QPS_OP_WR_SET   4'hC
`define QPS_OP_SET2WIP  4'hD
`define QPS_OP_WIP2SET  4'hE
`define QPS_OP_GSET2WIP 4'h1
`define QPS_OP_GWIP2SET 4'h8
`define QPS_OP_INCDEC   4'h2
`define QPS_OP_STATUS   4'h5
`define QPS_STATUS_POT  2'h1
`define QPS_F_TYPE      7:4
`define QPS_F_STRAP     1:0
`define QPS_F_OP        7:4
`define QPS_F_SEL       3:2
`define QPS_F_POT       1:0
`define QPS_F_VAL       5:0
`define QPS_REG_CMD     8'h00
`define QPS_REG_STAT    8'h04
`define QPS_C_STRAP     1:0
`define QPS_C_INSTR     15:8
`define QPS_C_DATA      23:16
`define QPS_C_STEPS     29:24
`define QPS_C_DIR       30
`define QPS_S_BUSY      0
`define QPS_S_READY     1
`define QPS_S_RX        15:8
`endif

/* File: hdl/qps_dev.sv */
// Quad 64-tap pot device: serial decode, wipers, stored settings.
// Assumes link pins arrive asynchronously and are resynchronised here.
//
// Contract
// - Frame opens with address byte, type in top
// - Continue only if address low bits match straps
// - Mismatched device executes nothing in that frame
// - Host drives middle address bits as zero
// - Second byte: opcode nibble, then setting select
// - Low two instruction bits select the pot
// - Setting select picks one of four settings
// - Four 6-bit wipers decoded one-hot to 64
// - Wipers change only by listed instructions
// - Power-up loads each wiper from first setting
// - Four 6-bit stored settings per pot
// - Transfers both ways, setting and wiper
// - Stored setting change completes within 5 ms
// - Save starts when select rises after write
// - Status read reports write busy bit
// - Host waits 1 ms after power-up
// - Opcode decode table incl status pot 01
// - Transfers two bytes; data commands three bytes
// - Step commands move wiper per clock pulse
`timescale 1ns/1ps
`default_nettype none
`include "qps_cfg.svh"
module qps_dev
  import qps_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE     = `QPS_DEV_TYPE, // Arbitrary value
  parameter int         NV_WRITE_CYC =
    `QPS_NV_WRITE_NS / `QPS_CLK_NS,
  parameter logic [5:0] NV_INIT      = `QPS_NV_INIT
) (
  input  wire logic         sys_clk,     // System clock
  input  wire logic         rst,         // Sync reset, high
  qps_if.dev                link,        // Serial pins
  input  wire logic [1:0]   strap_addr,  // Strap address pins
  output logic      [23:0]  wiper_pos,   // Four wiper values
  output logic      [255:0] tap_sel,     // One-hot taps, 64 per pot
  output logic              write_busy   // Save in progress
);

  // Pin synchronisers: first stage feeds only the second
  logic [1:0] sck_m, cs_m, si_m, st_m;
  logic       sck_q, sck_d, cs_q, cs_d, si_q;
  logic [1:0] strap_q;
  always_ff @(posedge sys_clk) begin
    sck_m   <= {1'b0, link.sck};
    cs_m    <= {1'b0, link.cs_n};
    si_m    <= {1'b0, link.si};
    st_m    <= strap_addr;
    sck_q   <= sck_m[0];
    sck_d   <= sck_q;
    cs_q    <= cs_m[0];
    cs_d    <= cs_q;
    si_q    <= si_m[0];
    strap_q <= st_m;
  end

  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = sck_q & ~sck_d;
  assign sck_fall = ~sck_q & sck_d;
  assign cs_rise  = cs_q & ~cs_d;

  // Frame and storage state
  qps_dev_state_e st_r, st_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt, ins_r, ins_nxt, tx_r, tx_nxt;
  logic        so_r, so_nxt, oe_r, oe_nxt;
  logic [5:0]  wip_r [4];
  logic [5:0]  wip_nxt [4];
  logic [5:0]  nv_r [16];
  logic [5:0]  nv_nxt [16];
  logic        pv_r, pv_nxt, pg_r, pg_nxt, load_r;
  logic [3:0]  pa_r, pa_nxt;
  logic [5:0]  pd_r, pd_nxt;
  logic [31:0] busy_r, busy_nxt;
  logic        wb_r, wb_nxt;

  // Next state of frame decoder, wipers and stored settings
  always_comb begin
    logic [7:0] rx;
    logic [1:0] pot;
    logic [1:0] sel;
    logic [3:0] op;
    logic       can_save;
    rx       = {sh_r[6:0], si_q};
    pot      = rx[`QPS_F_POT];
    sel      = rx[`QPS_F_SEL];
    op       = rx[`QPS_F_OP];
    can_save = (busy_r == 32'h0) && !pv_r;
    st_nxt   = st_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    ins_nxt  = ins_r;
    tx_nxt   = tx_r;
    so_nxt   = so_r;
    oe_nxt   = oe_r;
    wip_nxt  = wip_r;
    nv_nxt   = nv_r;
    pv_nxt   = pv_r;
    pg_nxt   = pg_r;
    pa_nxt   = pa_r;
    pd_nxt   = pd_r;
    busy_nxt = (busy_r != 32'h0) ? busy_r - 32'h1 : busy_r;
    if (load_r) begin
      for (int p = 0; p < 4; p++) begin
        wip_nxt[p] = nv_r[{2'(p), 2'b00}];
      end
    end
    if (cs_rise) begin
      // Select high closes the frame whatever its state
      st_nxt  = D_ADDR;
      bit_nxt = 3'h0;
      oe_nxt  = 1'b0;
      if (pv_r) begin
        // Commit happens only here, so an aborted write saves nothing
        if (pg_r) begin
          for (int p = 0; p < 4; p++) begin
            nv_nxt[{2'(p), pa_r[1:0]}] = wip_r[p];
          end
        end else begin
          nv_nxt[pa_r] = pd_r;
        end
        pv_nxt   = 1'b0;
        busy_nxt = 32'(NV_WRITE_CYC);
      end
    end else if (!cs_q) begin
      if (sck_rise) begin
        if (st_r == D_STEP) begin
          // Each pulse nudges one tap, pinned at both ends
          if (si_q && wip_r[ins_r[`QPS_F_POT]] != 6'h3F) begin
            wip_nxt[ins_r[`QPS_F_POT]] =
              wip_r[ins_r[`QPS_F_POT]] + 6'h01;
          end else if (!si_q && wip_r[ins_r[`QPS_F_POT]] != 6'h00) begin
            wip_nxt[ins_r[`QPS_F_POT]] =
              wip_r[ins_r[`QPS_F_POT]] - 6'h01;
          end
        end else if (st_r != D_IGNORE) begin
          sh_nxt  = rx;
          bit_nxt = bit_r + 3'h1;
        end
        if (bit_r == 3'h7 && st_r == D_ADDR) begin
          // Type and strap match gate the rest of the frame
          if (rx[`QPS_F_TYPE] == DEV_TYPE
              && rx[`QPS_F_STRAP] == strap_q) begin
            st_nxt = D_INSTR;
          end else begin
            st_nxt = D_IGNORE;
          end
        end else if (bit_r == 3'h7 && st_r == D_INSTR) begin
          ins_nxt = rx;
          st_nxt  = D_IGNORE;
          case (op)
            `QPS_OP_RD_WIPER: begin
              tx_nxt = {2'b00, wip_r[pot]};
              oe_nxt = 1'b1;
              st_nxt = D_DATA;
            end
            `QPS_OP_RD_SET: begin
              tx_nxt = {2'b00, nv_r[{pot, sel}]};
              oe_nxt = 1'b1;
              st_nxt = D_DATA;
            end
            `QPS_OP_WR_WIPER, `QPS_OP_WR_SET: begin
              st_nxt = D_DATA;
            end
            `QPS_OP_SET2WIP: begin
              wip_nxt[pot] = nv_r[{pot, sel}];
            end
            `QPS_OP_GSET2WIP: begin
              for (int p = 0; p < 4; p++) begin
                wip_nxt[p] = nv_r[{2'(p), sel}];
              end
            end
            `QPS_OP_WIP2SET: begin
              if (can_save) begin
                pv_nxt = 1'b1;
                pg_nxt = 1'b0;
                pa_nxt = {pot, sel};
                pd_nxt = wip_r[pot];
              end
            end
            `QPS_OP_GWIP2SET: begin
              if (can_save) begin
                pv_nxt = 1'b1;
                pg_nxt = 1'b1;
                pa_nxt = {2'b00, sel};
              end
            end
            `QPS_OP_INCDEC: begin
              st_nxt = D_STEP;
            end
            `QPS_OP_STATUS: begin
              if (pot == `QPS_STATUS_POT) begin
                tx_nxt = {7'h00, wb_r};
                oe_nxt = 1'b1;
                st_nxt = D_DATA;
              end
            end
            default: st_nxt = D_IGNORE;
          endcase
        end else if (bit_r == 3'h7 && st_r == D_DATA) begin
          // Bytes past the third are ignored
          st_nxt = D_IGNORE;
          if (ins_r[`QPS_F_OP] == `QPS_OP_WR_WIPER) begin
            wip_nxt[ins_r[`QPS_F_POT]] = rx[`QPS_F_VAL];
          end else if (ins_r[`QPS_F_OP] == `QPS_OP_WR_SET && can_save) begin
            pv_nxt = 1'b1;
            pg_nxt = 1'b0;
            pa_nxt = {ins_r[`QPS_F_POT], ins_r[`QPS_F_SEL]};
            pd_nxt = rx[`QPS_F_VAL];
          end
        end
      end
      // Read data leaves on falling edges, host samples on rising
      if (sck_fall && oe_r) begin
        so_nxt = tx_r[7];
        tx_nxt = {tx_r[6:0], 1'b0};
      end
    end
    wb_nxt = (busy_nxt != 32'h0) || pv_nxt;
  end

  // Registers; stored settings take their factory value at reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r   <= D_ADDR;
      bit_r  <= 3'h0;
      sh_r   <= 8'h00;
      ins_r  <= 8'h00;
      tx_r   <= 8'h00;
      so_r   <= 1'b0;
      oe_r   <= 1'b0;
      pv_r   <= 1'b0;
      pg_r   <= 1'b0;
      pa_r   <= 4'h0;
      pd_r   <= 6'h00;
      busy_r <= 32'h0;
      wb_r   <= 1'b0;
      load_r <= 1'b1;
      for (int p = 0; p < 4; p++) begin
        wip_r[p] <= 6'h00;
      end
      for (int i = 0; i < 16; i++) begin
        nv_r[i] <= NV_INIT;
      end
    end else begin
      st_r   <= st_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      ins_r  <= ins_nxt;
      tx_r   <= tx_nxt;
      so_r   <= so_nxt;
      oe_r   <= oe_nxt;
      pv_r   <= pv_nxt;
      pg_r   <= pg_nxt;
      pa_r   <= pa_nxt;
      pd_r   <= pd_nxt;
      busy_r <= busy_nxt;
      wb_r   <= wb_nxt;
      load_r <= 1'b0;
      wip_r  <= wip_nxt;
      nv_r   <= nv_nxt;
    end
  end

  // Tap decode per pot, registered so outputs stay glitch free
  for (genvar p = 0; p < 4; p++) begin : g_tap
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        tap_sel[p*64 +: 64] <= 64'h1;
      end else begin
        tap_sel[p*64 +: 64] <= 64'h1 << wip_nxt[p];
      end
    end
    assign wiper_pos[p*6 +: 6] = wip_r[p];
  end

  assign link.so    = so_r;
  assign link.so_oe = oe_r;
  assign write_busy = wb_r;

endmodule : qps_dev
`default_nettype wire

/* File: hdl/qps_host.sv */
// Host controller for the quad pot link: APB registers drive frames.
// Assumes an APB master on sys_clk and the device across qps_if.
`timescale 1ns/1ps
`default_nettype none
`include "qps_cfg.svh"
module qps_host
  import qps_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = `QPS_DEV_TYPE, // Arbitrary value
  parameter int PU_CYC   = `QPS_PWRUP_NS / `QPS_CLK_NS,
  parameter int HALF_CYC = (1000000 + 2 * `QPS_SCK_MAX_KHZ * `QPS_CLK_NS
                            - 1) / (2 * `QPS_SCK_MAX_KHZ * `QPS_CLK_NS)
) (
  input  wire logic        sys_clk,  // System clock
  input  wire logic        rst,      // Sync reset, high
  input  wire logic [7:0]  paddr,    // APB address
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error, unmapped
  qps_if.host              link      // Serial pins
);

  // Device output crosses in through two flops
  logic so_m, so_q;
  always_ff @(posedge sys_clk) begin
    so_m <= link.so;
    so_q <= so_m;
  end

  qps_host_state_e st_r, st_nxt;
  logic [31:0] cmd_r, cmd_nxt, pu_r, pu_nxt, prd_r, prd_nxt;
  logic [15:0] div_r, div_nxt;
  logic [23:0] tx_r, tx_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic [6:0]  cnt_r, cnt_nxt, nb_r, nb_nxt;
  logic        sck_r, sck_nxt, cs_r, cs_nxt, si_r, si_nxt;
  logic        rdy_r, rdy_nxt, err_r, err_nxt;

  // Next state of APB slave and serial sequencer
  always_comb begin
    logic       tick;
    logic       go;
    logic [3:0] op;
    tick    = (div_r == 16'(HALF_CYC - 1));
    op      = pwdata[15:12];
    go      = psel && penable && rdy_r && pwrite
              && paddr == `QPS_REG_CMD;
    st_nxt  = st_r;
    cmd_nxt = cmd_r;
    div_nxt = (st_r == H_IDLE || tick) ? 16'h0 : div_r + 16'h1;
    tx_nxt  = tx_r;
    rx_nxt  = rx_r;
    cnt_nxt = cnt_r;
    nb_nxt  = nb_r;
    sck_nxt = sck_r;
    cs_nxt  = cs_r;
    si_nxt  = si_r;
    // Power-up wait before any frame
    pu_nxt  = (pu_r != 32'(PU_CYC)) ? pu_r + 32'h1 : pu_r;
    // Zero-wait answer: ready rises in the access cycle
    rdy_nxt = psel && !penable;
    err_nxt = psel && !penable && paddr != `QPS_REG_CMD
              && paddr != `QPS_REG_STAT;
    prd_nxt = 32'h0;
    if (paddr == `QPS_REG_CMD) begin
      prd_nxt = cmd_r;
    end else if (paddr == `QPS_REG_STAT) begin
      prd_nxt[`QPS_S_BUSY]  = (st_r != H_IDLE);
      prd_nxt[`QPS_S_READY] = (pu_r == 32'(PU_CYC));
      prd_nxt[`QPS_S_RX]    = rx_r;
    end
    if (go) begin
      cmd_nxt = pwdata;
    end
    case (st_r)
      H_IDLE: begin
        // Commands while busy or before power-up are dropped
        if (go && pu_r == 32'(PU_CYC)) begin
          tx_nxt = {DEV_TYPE, 2'b00, pwdata[`QPS_C_STRAP],
                    pwdata[`QPS_C_INSTR],
                    pwdata[`QPS_C_DATA]};
          si_nxt = DEV_TYPE[3];
          cs_nxt = 1'b0;
          cnt_nxt = 7'h0;
          if (op == `QPS_OP_INCDEC) begin
            nb_nxt = 7'd16 + {1'b0, pwdata[`QPS_C_STEPS]};
            tx_nxt[7:0] = {8{pwdata[`QPS_C_DIR]}};
          end else if (op == `QPS_OP_RD_WIPER || op == `QPS_OP_WR_WIPER
                       || op == `QPS_OP_RD_SET || op == `QPS_OP_WR_SET
                       || op == `QPS_OP_STATUS) begin
            nb_nxt = 7'd24;
          end else begin
            nb_nxt = 7'd16;
          end
          st_nxt = H_LEAD;
        end
      end
      H_LEAD: if (tick) st_nxt = H_SHIFT;
      H_SHIFT: begin
        if (tick && !sck_r) begin
          sck_nxt = 1'b1;
          rx_nxt  = {rx_r[6:0], so_q};
        end else if (tick) begin
          sck_nxt = 1'b0;
          cnt_nxt = cnt_r + 7'h1;
          tx_nxt  = {tx_r[22:0], tx_r[0]};
          si_nxt  = tx_r[22];
          if (cnt_r + 7'h1 == nb_r) begin
            st_nxt = H_END;
          end
        end
      end
      H_END: begin
        if (tick) begin
          cs_nxt  = 1'b1;
          cnt_nxt = 7'h0;
          st_nxt  = H_GAP;
        end
      end
      H_GAP: begin
        // Two half periods keep select high long enough
        if (tick) begin
          cnt_nxt = cnt_r + 7'h1;
          if (cnt_r == 7'h1) st_nxt = H_IDLE;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r  <= H_IDLE;
      cmd_r <= 32'h0;
      pu_r  <= 32'h0;
      prd_r <= 32'h0;
      div_r <= 16'h0;
      tx_r  <= 24'h0;
      rx_r  <= 8'h00;
      cnt_r <= 7'h0;
      nb_r  <= 7'h0;
      sck_r <= 1'b0;
      cs_r  <= 1'b1;
      si_r  <= 1'b0;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cmd_r <= cmd_nxt;
      pu_r  <= pu_nxt;
      prd_r <= prd_nxt;
      div_r <= div_nxt;
      tx_r  <= tx_nxt;
      rx_r  <= rx_nxt;
      cnt_r <= cnt_nxt;
      nb_r  <= nb_nxt;
      sck_r <= sck_nxt;
      cs_r  <= cs_nxt;
      si_r  <= si_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
    end
  end

  assign prdata    = prd_r;
  assign pready    = rdy_r;
  assign pslverr   = err_r;
  assign link.sck  = sck_r;
  assign link.cs_n = cs_r;
  assign link.si   = si_r;

endmodule : qps_host
`default_nettype wire

/* File: hdl/qps_if.sv */
// Serial link between the quad pot device and its host controller.
// Each wire has a single driver; so_oe marks the device driving.
`timescale 1ns/1ps
`default_nettype none
interface qps_if;
  logic sck;   // Serial clock from host
  logic cs_n;  // Frame select, active low
  logic si;    // Host to device data
  logic so;    // Device to host data
  logic so_oe; // Device drives so
  modport dev  (input sck, cs_n, si, output so, so_oe);
  modport host (output sck, cs_n, si, input so, so_oe);
endinterface : qps_if
`default_nettype wire

/* File: hdl/qps_pkg.sv */
// Types shared by both ends of the quad pot serial link.
// Assumes nothing beyond a SystemVerilog compiler.
package qps_pkg;
  typedef enum logic [2:0] {
    D_ADDR, D_INSTR, D_DATA, D_STEP, D_IGNORE
  } qps_dev_state_e;
  typedef enum logic [2:0] {
    H_IDLE, H_LEAD, H_SHIFT, H_END, H_GAP
  } qps_host_state_e;
endpackage : qps_pkg

/* File: test/qps_checker.sv */
// Checker of the quad pot serial link, watching only the shared pins.
// Assumes one sys_clk domain and a host half period of 8 sys_clk.
`timescale 1ns/1ps
`default_nettype none
module qps_checker #(
  parameter logic [3:0] DEV_TYPE = 4'hA // Arbitrary value
) (
  input wire logic sys_clk, // System clock
  input wire logic rst,     // Sync reset, high
  input wire logic sck,     // Serial clock
  input wire logic cs_n,    // Frame select, low
  input wire logic si,      // Host to device
  input wire logic so,      // Device to host
  input wire logic so_oe    // Device drives so
);
  logic       sck_q_r, sck_q_nxt;
  logic [7:0] rise_r,  rise_nxt; // Rising sck edges in frame
  logic [7:0] sh_r,    sh_nxt;   // Bits sampled at rises
  logic [3:0] age_r,   age_nxt;  // Cycles since last fall
  logic       up_w;
  assign up_w = sck & ~sck_q_r;
  // Frame bookkeeping; select high clears the edge count
  always_comb begin
    sck_q_nxt = sck;
    rise_nxt  = cs_n ? 8'h00 : rise_r + {7'h00, up_w};
    sh_nxt    = up_w ? {sh_r[6:0], si} : sh_r;
    age_nxt   = (~sck & sck_q_r) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sck_q_r <= 1'b0;
      rise_r  <= 8'h00;
      sh_r    <= 8'h00;
      age_r   <= 4'hF;
    end else begin
      sck_q_r <= sck_q_nxt;
      rise_r  <= rise_nxt;
      sh_r    <= sh_nxt;
      age_r   <= age_nxt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence sck_held_low;
    !sck [*8];
  endsequence
  sequence cs_held_high;
    cs_n [*7];
  endsequence
  addr_byte_a: assert property (
    rise_r == 8'h08 && $past(rise_r) == 8'h07
    |-> sh_r[7:4] == DEV_TYPE && sh_r[3:2] == 2'b00)
    else $error("address byte malformed");
  read_turn_a: assert property (
    $rose(so_oe) |-> rise_r == 8'h10)
    else $error("so enabled outside instruction end");
  pad_bits_a: assert property (
    so_oe && up_w && rise_r < 8'h12 |-> !so)
    else $error("read byte top bits not zero");
  so_hold_a: assert property (
    so_oe && $past(so_oe) && $changed(so) |-> age_r <= 4'h6)
    else $error("so changed away from sck fall");
  frame_end_a: assert property (
    $rose(cs_n) |-> ##[0:6] !so_oe)
    else $error("so still driven after frame end");
  idle_quiet_a: assert property (
    cs_n [*8] |-> !so_oe && !sck)
    else $error("link active while deselected");
  cs_gap_a: assert property (
    $rose(cs_n) |=> cs_held_high)
    else $error("select high time too short");
  lead_quiet_a: assert property (
    $fell(cs_n) |-> sck_held_low)
    else $error("sck rose too soon after select");
endmodule : qps_checker
`default_nettype wire

/* File: test/tb_quad_pot_serial_control.sv */
// Bench: host and device joined over the link, driven through APB.
// Assumes both ends share DEV_TYPE; stored settings reset to NVI.
`timescale 1ns/1ps
`default_nettype none
`include "qps_cfg.svh"
module tb_quad_pot_serial_control;
  localparam int NV = 2000;
  // Factory value kept off zero so the power-up load is visible
  localparam logic [5:0] NVI = 6'h15;
  logic         sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic         wbusy, err, pend;
  logic [1:0]   strap;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [23:0]  wiper_pos;
  logic [255:0] tap_sel;
  logic [5:0]   write_busy_flag [4];
  logic [5:0]   st  [4][4];
  logic [3:0]   ops [10];
  int           error_cnt, n_compared, seed, cyc;
  qps_if lnk ();
  qps_dev #(.NV_WRITE_CYC(NV), .NV_INIT(NVI)) qps_dev_i (
    .sys_clk(sys_clk), .rst(rst),
    .link(lnk), .strap_addr(strap), .wiper_pos(wiper_pos),
    .tap_sel(tap_sel), .write_busy(wbusy));
  qps_host #(.PU_CYC(50), .HALF_CYC(8)) qps_host_i (.sys_clk(sys_clk),
    .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk));
  qps_checker #(.DEV_TYPE(`QPS_DEV_TYPE)) qps_checker_i (.sys_clk(sys_clk),
    .rst(rst), .sck(lnk.sck), .cs_n(lnk.cs_n), .si(lnk.si), .so(lnk.so),
    .so_oe(lnk.so_oe));
  // Clock of 4 ns
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [255:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input int b, input logic lvl);
    int k;
    k = 0;
    do begin
      apb(1'b0, `QPS_REG_STAT, 32'h0);
      k++;
    end while (rd[b] !== lvl && k < 3000);
    chk("stat_poll", lvl, rd[b]);
  endtask : poll
  // Instruction byte with the fixed fields of each opcode
  function automatic logic [7:0] mk(input logic [3:0] op,
                                    input logic [1:0] s, p);
    case (op)
      `QPS_OP_STATUS: return {op, 2'b00, `QPS_STATUS_POT};
      `QPS_OP_GSET2WIP, `QPS_OP_GWIP2SET: return {op, s, 2'b00};
      `QPS_OP_RD_WIPER, `QPS_OP_WR_WIPER, `QPS_OP_INCDEC:
        return {op, 2'b00, p};
      default: return {op, s, p};
    endcase
  endfunction : mk
  // Device model: updates wipers and settings, returns read byte
  function automatic logic [7:0] model(input logic [7:0] ins,
                                       input logic [5:0] d, n, input logic up);
    logic [1:0] s, p;
    s = ins[3:2];
    p = ins[1:0];
    case (ins[7:4])
      `QPS_OP_WR_WIPER: write_busy_flag[p] = d;
      `QPS_OP_WR_SET:   if (!pend) st[p][s] = d;
      `QPS_OP_SET2WIP:  write_busy_flag[p] = st[p][s];
      `QPS_OP_WIP2SET:  if (!pend) st[p][s] = write_busy_flag[p];
      `QPS_OP_GSET2WIP: for (int i = 0; i < 4; i++) write_busy_flag[i] = st[i][s];
      `QPS_OP_GWIP2SET: if (!pend)
        for (int i = 0; i < 4; i++) st[i][s] = write_busy_flag[i];
      `QPS_OP_INCDEC:   for (int i = 0; i < n; i++)
        write_busy_flag[p] = up ? write_busy_flag[p] + {5'h00, write_busy_flag[p] != 6'h3F}
                    : write_busy_flag[p] - {5'h00, write_busy_flag[p] != 6'h00};
      `QPS_OP_RD_WIPER: return {2'b00, write_busy_flag[p]};
      `QPS_OP_RD_SET:   return {2'b00, st[p][s]};
      default:          return {7'h00, pend};
    endcase
    return 8'h00;
  endfunction : model
  // Send a frame, then check read byte, wipers, taps and save window
  task automatic send(input logic [7:0] ins, input logic [5:0] d, n,
                      input logic up, hit);
    logic [7:0]   ex;
    logic [255:0] tx;
    logic         sv;
    int           k;
    sv = hit && !pend && (ins[7:4] == `QPS_OP_WR_SET ||
         ins[7:4] == `QPS_OP_WIP2SET || ins[7:4] == `QPS_OP_GWIP2SET);
    apb(1'b1, `QPS_REG_CMD, {1'b0, up, n, 2'b00, d, ins, 6'h00,
        hit ? strap : ~strap});
    poll(`QPS_S_BUSY, 1'b0);
    ex = hit ? model(ins, d, n, up) : 8'h00;
    if (hit && ins[7:4] inside {4'h9, 4'hB, 4'h5})
      chk("read_byte", ex, rd[15:8]);
    chk("wiper_pos", {write_busy_flag[3], write_busy_flag[2], write_busy_flag[1], write_busy_flag[0]},
        wiper_pos);
    tx = '0;
    for (int i = 0; i < 4; i++) tx[i * 64 + int'(write_busy_flag[i])] = 1'b1;
    chk("tap_sel", tx, tap_sel);
    if (sv) begin
      // Save must be running once the host reports the frame done
      chk("busy_set", 1'b1, wbusy);
      pend = 1'b1;
      send(8'h51, 6'h00, 6'h00, 1'b0, 1'b1);
      send({4'hC, ins[3:2], ins[1:0]}, ~d, 6'h00, 1'b0, 1'b1);
      send({4'hB, ins[3:2], ins[1:0]}, 6'h00, 6'h00, 1'b0, 1'b1);
      k = 0;
      while (wbusy !== 1'b0 && k < NV) begin
        @(posedge sys_clk);
        k++;
      end
      chk("write_busy", 1'b0, wbusy);
      pend = 1'b0;
    end
  endtask : send
  task automatic rnd_send(input int oi, input logic hit);
    logic [31:0] r;
    r = $random(seed);
    send(mk(ops[oi], r[14:13], r[16:15]), r[5:0], r[11:6], r[12], hit);
  endtask : rnd_send
  // Main sequence: reset, power-up wait, each opcode, corners, random
  initial begin
    seed = 21;
    ops = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h1, 4'h8, 4'h2, 4'h5};
    strap = 2'($random(seed));
    {psel, penable, pwrite, paddr, pwdata, pend} = '0;
    rst = 1'b1;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    for (int i = 0; i < 4; i++) begin
      write_busy_flag[i] = NVI;
      for (int j = 0; j < 4; j++) st[i][j] = NVI;
    end
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    poll(`QPS_S_READY, 1'b1);
    send(8'h51, 6'h00, 6'h00, 1'b0, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped_err", 1'b1, err);
    chk("unmapped_data", 32'h0, rd);
    for (int i = 0; i < 10; i++)
      rnd_send(i, 1'b1);
    // Undefined opcode must leave every wiper alone
    send(8'h3F, 6'h00, 6'h00, 1'b0, 1'b1);
    send(8'hA2, 6'h3E, 6'h00, 1'b0, 1'b1);
    send(8'h22, 6'h00, 6'h05, 1'b1, 1'b1);
    send(8'hA1, 6'h01, 6'h00, 1'b0, 1'b1);
    send(8'h21, 6'h00, 6'h04, 1'b0, 1'b1);
    for (int i = 0; i < 24; i++)
      rnd_send(int'($unsigned($random(seed)) % 10),
               ($random(seed) % 6) != 0);
    tally_and_finish();
  end
endmodule : tb_quad_pot_serial_control
`default_nettype wire
